/* rtl/qflag_consts.vh */
// Constants for the queue flag status and power-down block.
`ifndef QFLAG_CONSTS_VH
`define QFLAG_CONSTS_VH
`define NUM_QUEUES 8
`define QSEL_W 3
`define DEV_W 3
`define CLK_PERIOD_NS 100
`define WAKE_TIME_NS 1000
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AE_ASSERT_LAT 2
`define AE_DEASSERT_LAT 1
`define AF_DEASSERT_LAT 1
`define STATUS_BUS_LAT 1
`define FLAGS_RESET 8'hff
`endif

/* rtl/flag_delay.v */
// Per-queue flag latency stage with optional extra cycle on skew violation.
`timescale 1ns/100ps
`default_nettype none
module flag_delay (
  input wire clock,
  input wire rst,
  input wire hold,
  input wire assert_evt,
  input wire deassert_evt,
  input wire skew_violation,
  output reg flag_n_r
);
  reg a1_r;
  reg a2_r;
  reg d1_r;
  reg d2_r;
  reg dsk_r;
  // Assertion takes two cycles; de-assertion one, plus one on a skew violation.
  always @(posedge clock) begin
    if (rst) begin
      a1_r <= 1'b0;
      a2_r <= 1'b0;
      d1_r <= 1'b0;
      d2_r <= 1'b0;
      dsk_r <= 1'b0;
      flag_n_r <= 1'b1;
    end else if (!hold) begin
      a1_r <= assert_evt;
      a2_r <= a1_r;
      d1_r <= deassert_evt & ~skew_violation;
      dsk_r <= deassert_evt & skew_violation;
      d2_r <= dsk_r;
      // A new threshold crossing wins over a pending release, so the flag never lies high.
      // Assertion is taken from the second stage to give the two-cycle latency.
      if (a2_r)
        flag_n_r <= 1'b0;
      else if (d1_r | d2_r)
        flag_n_r <= 1'b1;
    end
  end
endmodule // flag_delay
`default_nettype wire

/* rtl/queue_flag_status.v */
// Flag status busses, echo read enable and power-down sequencing of a multi-queue FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "qflag_consts.vh"
module queue_flag_status (
  input wire clock,
  input wire rst,
  input wire [7:0] ae_assert_evt,
  input wire [7:0] ae_deassert_evt,
  input wire [7:0] af_assert_evt,
  input wire [7:0] af_deassert_evt,
  input wire skew_violation,
  input wire [2:0] read_queue_sel,
  input wire [2:0] write_queue_sel,
  input wire read_enable_n,
  input wire word_available,
  input wire last_word,
  input wire [2:0] ae_bus_dev_sel,
  input wire ae_bus_sel_strobe,
  input wire [2:0] af_bus_dev_sel,
  input wire af_bus_sel_strobe,
  input wire [2:0] device_id,
  input wire expansion_chain_input,
  input wire owns_output_bus,
  input wire power_down_input,
  input wire [7:0] static_config,
  output reg [7:0] almost_empty_status_bus,
  output reg almost_empty_status_bus_oe,
  output reg [7:0] almost_full_status_bus,
  output reg almost_full_status_bus_oe,
  output reg almost_empty_flag,
  output reg almost_full_flag,
  output reg flags_oe,
  output reg echo_read_enable_n,
  output wire echo_read_clock,
  output reg output_valid_flag_n,
  output reg output_oe,
  output wire expansion_chain_output,
  output reg [7:0] active_config,
  output wire serial_port_enable,
  output wire test_port_enable,
  output wire host_io_ready
);
  // ****************************************************************
  // Power-down state machine
  // ****************************************************************
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_DOWN = 2'b01;
  localparam [1:0] ST_WAKE = 2'b10;
  localparam [31:0] WAKE_SPAN = `WAKE_CYCLES - 1;
  localparam [3:0] WAKE_LAST = WAKE_SPAN[3:0];
  reg [1:0] pd_state_r;
  reg [1:0] pd_state_nxt;
  reg [3:0] wake_cnt_r;
  reg [3:0] wake_cnt_nxt;
  wire running;
  wire held;
  // The wake count starts at the release edge so outputs stay idle the full microsecond.
  always @* begin
    pd_state_nxt = pd_state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (pd_state_r)
      ST_RUN: begin
        if (power_down_input)
          pd_state_nxt = ST_DOWN;
      end
      ST_DOWN: begin
        wake_cnt_nxt = 4'h0;
        if (!power_down_input)
          pd_state_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (power_down_input) begin
          pd_state_nxt = ST_DOWN;
        end else if (wake_cnt_r == WAKE_LAST) begin
          pd_state_nxt = ST_RUN;
        end else begin
          wake_cnt_nxt = wake_cnt_r + 4'h1;
        end
      end
      default: begin
        pd_state_nxt = ST_RUN;
      end
    endcase
  end
  // State register for the power-down sequence.
  always @(posedge clock) begin
    if (rst) begin
      pd_state_r <= ST_RUN;
      wake_cnt_r <= 4'h0;
    end else begin
      pd_state_r <= pd_state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end
  assign running = (pd_state_r == ST_RUN) && !power_down_input;
  assign held = !running;
  assign host_io_ready = running;
  assign serial_port_enable = running;
  assign test_port_enable = running;
  // ****************************************************************
  // Static configuration
  // ****************************************************************
  // Configuration is latched only while running, so power down leaves it in effect.
  always @(posedge clock) begin
    if (rst)
      active_config <= 8'h00;
    else if (running)
      active_config <= static_config;
  end
  // ****************************************************************
  // Per-queue flag latency stages
  // ****************************************************************
  wire [7:0] ae_n;
  wire [7:0] af_n;
  genvar q;
  generate
    for (q = 0; q < `NUM_QUEUES; q = q + 1) begin : g_queue
      // Flag stages hold their state through power down.
      flag_delay u_ae (
        .clock(clock),
        .rst(rst),
        .hold(held),
        .assert_evt(ae_assert_evt[q]),
        .deassert_evt(ae_deassert_evt[q]),
        .skew_violation(skew_violation),
        .flag_n_r(ae_n[q])
      );
      flag_delay u_af (
        .clock(clock),
        .rst(rst),
        .hold(held),
        .assert_evt(af_assert_evt[q]),
        .deassert_evt(af_deassert_evt[q]),
        .skew_violation(skew_violation),
        .flag_n_r(af_n[q])
      );
    end
  endgenerate
  // ****************************************************************
  // Direct-mode status busses
  // ****************************************************************
  reg ae_sel_r;
  reg af_sel_r;
  reg ae_boot_r;
  reg af_boot_r;
  wire is_master;
  assign is_master = ~expansion_chain_input;
  assign expansion_chain_output = 1'b0;
  // Selection registers: the master owns the busses after reset, others wait.
  // The master claims a bus only until the first selection strobe; after that it
  // would fight the device that the host picked.
  always @(posedge clock) begin
    if (rst) begin
      ae_sel_r <= 1'b0;
      af_sel_r <= 1'b0;
      ae_boot_r <= 1'b1;
      af_boot_r <= 1'b1;
    end else if (running) begin
      if (ae_bus_sel_strobe) begin
        ae_sel_r <= (ae_bus_dev_sel == device_id);
        ae_boot_r <= 1'b0;
      end else if (ae_boot_r && !ae_sel_r && is_master && !almost_empty_status_bus_oe) begin
        ae_sel_r <= 1'b1;
      end
      if (af_bus_sel_strobe) begin
        af_sel_r <= (af_bus_dev_sel == device_id);
        af_boot_r <= 1'b0;
      end else if (af_boot_r && !af_sel_r && is_master && !almost_full_status_bus_oe) begin
        af_sel_r <= 1'b1;
      end
    end
  end
  // Bus outputs update one cycle after selection; enables switch on the same edge
  // in every device, so the old driver lets go as the new one drives.
  always @(posedge clock) begin
    if (rst) begin
      almost_empty_status_bus <= `FLAGS_RESET;
      almost_full_status_bus <= `FLAGS_RESET;
      almost_empty_status_bus_oe <= 1'b0;
      almost_full_status_bus_oe <= 1'b0;
    end else if (running) begin
      almost_empty_status_bus <= ae_n;
      almost_full_status_bus <= af_n;
      almost_empty_status_bus_oe <= ae_sel_r;
      almost_full_status_bus_oe <= af_sel_r;
    end else begin
      almost_empty_status_bus_oe <= 1'b0;
      almost_full_status_bus_oe <= 1'b0;
    end
  end
  // ****************************************************************
  // Discrete flags, echo enable and output valid
  // ****************************************************************
  wire new_word;
  assign new_word = owns_output_bus && !read_enable_n && word_available;
  // Discrete flags mirror the selected queues; echo enable low only for a new word.
  always @(posedge clock) begin
    if (rst) begin
      almost_empty_flag <= 1'b1;
      almost_full_flag <= 1'b1;
      echo_read_enable_n <= 1'b1;
      output_valid_flag_n <= 1'b1;
      flags_oe <= 1'b0;
      output_oe <= 1'b0;
    end else if (running) begin
      almost_empty_flag <= ae_n[read_queue_sel];
      almost_full_flag <= af_n[write_queue_sel];
      echo_read_enable_n <= ~new_word;
      flags_oe <= 1'b1;
      output_oe <= owns_output_bus;
      if (new_word)
        output_valid_flag_n <= 1'b0;
      else if (last_word || !word_available)
        output_valid_flag_n <= 1'b1;
    end else begin
      // Flags keep their value; the drivers are released and echo enable is driven high.
      flags_oe <= 1'b0;
      output_oe <= 1'b0;
      echo_read_enable_n <= 1'b1;
    end
  end
  // Forwarded clock; receivers capture echo outputs on its rising edge.
  assign echo_read_clock = clock & running;
endmodule // queue_flag_status
`default_nettype wire

/* verification/queue_flag_status_checker.sv */
// Concurrent checks on the ports of the queue flag status block.
`timescale 1ns/100ps
`default_nettype none
module queue_flag_status_checker (
  input wire clock,
  input wire rst,
  input wire [7:0] ae_assert_evt,
  input wire [7:0] ae_deassert_evt,
  input wire skew_violation,
  input wire read_enable_n,
  input wire word_available,
  input wire last_word,
  input wire [2:0] ae_bus_dev_sel,
  input wire ae_bus_sel_strobe,
  input wire [2:0] af_bus_dev_sel,
  input wire af_bus_sel_strobe,
  input wire [2:0] device_id,
  input wire power_down_input,
  input wire [7:0] almost_empty_status_bus,
  input wire almost_empty_status_bus_oe,
  input wire almost_full_status_bus_oe,
  input wire almost_empty_flag,
  input wire echo_read_enable_n,
  input wire output_valid_flag_n,
  input wire output_oe,
  input wire test_port_enable,
  input wire host_io_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Requests only count while running; a bus held by another device shows nothing of ours.
  wire alive = host_io_ready && !power_down_input;
  wire live = alive && almost_empty_status_bus_oe;
  sequence s_wake;
    (!host_io_ready) [*8];
  endsequence
  // Queue three carries the flag latency checks.
  a_ae_assert_lat: assert property (live && ae_assert_evt[3] |-> ##4 !almost_empty_status_bus[3])
    else $error("late assert");
  a_ae_clear_lat: assert property (live && ae_deassert_evt[3] && !skew_violation && !ae_assert_evt[3]
    && !almost_empty_status_bus[3] |-> ##2 !almost_empty_status_bus[3] ##1 almost_empty_status_bus[3])
    else $error("late clear");
  a_ae_skew_extra: assert property (live && ae_deassert_evt[3] && skew_violation && !almost_empty_status_bus[3]
    |-> ##3 !almost_empty_status_bus[3] ##1 almost_empty_status_bus[3]) else $error("skew cycle");
  a_ae_bus_take: assert property (ae_bus_sel_strobe && ae_bus_dev_sel == device_id |-> ##3 almost_empty_status_bus_oe)
    else $error("ae take");
  a_ae_bus_drop: assert property (ae_bus_sel_strobe && ae_bus_dev_sel != device_id |-> ##3 !almost_empty_status_bus_oe)
    else $error("ae drop");
  a_af_bus_take: assert property (af_bus_sel_strobe && af_bus_dev_sel == device_id |-> ##3 almost_full_status_bus_oe)
    else $error("af take");
  a_echo_new_word: assert property (alive && !read_enable_n && word_available |=> !echo_read_enable_n)
    else $error("echo high");
  a_echo_no_word: assert property (alive && (read_enable_n || !word_available) |=> echo_read_enable_n)
    else $error("echo low");
  a_valid_empty: assert property (alive && !word_available |=> output_valid_flag_n) else $error("valid empty");
  a_valid_word: assert property (alive && !read_enable_n && word_available && !last_word |=> !output_valid_flag_n)
    else $error("valid word");
  a_pd_quiet: assert property (power_down_input |=> !output_oe && !almost_empty_status_bus_oe && !test_port_enable)
    else $error("pd drive");
  a_pd_hold: assert property (power_down_input |=> $stable(almost_empty_flag)) else $error("pd flag");
  a_wake_gap: assert property ($fell(power_down_input) |-> s_wake ##[1:4] host_io_ready) else $error("wake");
endmodule // queue_flag_status_checker
bind queue_flag_status queue_flag_status_checker u_queue_flag_status_checker (.*);
`default_nettype wire

/* verification/host_reads.sv */
// Host-side read model that feeds the read port of the flag block.
`timescale 1ns/100ps
`default_nettype none
module host_reads (
  input wire clock,
  input wire run,
  output reg read_enable_n = 1'b1,
  output reg word_available = 1'b0,
  output reg last_word = 1'b0
);
  reg [2:0] step_r = 3'h0;
  // A pause, a last word and an empty slot per lap; all quiet while run is low.
  always @(posedge clock) begin
    step_r <= run ? step_r + 3'h1 : 3'h0;
    read_enable_n <= #2 !(run && step_r != 3'h2);
    word_available <= #2 run && step_r != 3'h6;
    last_word <= #2 run && step_r == 3'h5;
  end
endmodule // host_reads
`default_nettype wire

/* verification/queue_flag_status_test.sv */
// Self-checking bench for the queue flag status block.
`timescale 1ns/100ps
`default_nettype none
module queue_flag_status_test;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [7:0] ae_set = 8'h00, ae_clr = 8'h00, af_set = 8'h00, af_clr = 8'h00;
  reg skew = 1'b0, ae_stb = 1'b0, af_stb = 1'b0, pd = 1'b0, run = 1'b0;
  reg [2:0] dev = 3'h0;
  reg [7:0] cfg_in = 8'h5a;
  reg exp_n = 1'b1;
  wire rd_n, avail, last, ae_oe, af_oe, ae_flag, af_flag, q_oe, ready;
  wire echo_n, ov_n, f_oe, tport, sport, xout;
  wire [7:0] ae_bus, af_bus, cfg;
  integer fails = 0, comparisons = 0, n;
  // The clock toggles every half period of 100 ns.
  initial begin
    forever #50 clock = ~clock;
  end
  host_reads u_host_reads (.clock(clock), .run(run), .read_enable_n(rd_n), .word_available(avail), .last_word(last));
  queue_flag_status u_queue_flag_status (.clock(clock), .rst(rst), .ae_assert_evt(ae_set), .ae_deassert_evt(ae_clr),
    .af_assert_evt(af_set), .af_deassert_evt(af_clr), .skew_violation(skew), .read_queue_sel(3'h3),
    .write_queue_sel(3'h1), .read_enable_n(rd_n), .word_available(avail), .last_word(last), .ae_bus_dev_sel(dev),
    .ae_bus_sel_strobe(ae_stb), .af_bus_dev_sel(dev), .af_bus_sel_strobe(af_stb), .device_id(3'h0),
    .expansion_chain_input(1'b0), .owns_output_bus(1'b1), .power_down_input(pd), .static_config(cfg_in),
    .almost_empty_status_bus(ae_bus), .almost_empty_status_bus_oe(ae_oe), .almost_full_status_bus(af_bus),
    .almost_full_status_bus_oe(af_oe), .almost_empty_flag(ae_flag), .almost_full_flag(af_flag), .flags_oe(f_oe),
    .echo_read_enable_n(echo_n), .echo_read_clock(), .output_valid_flag_n(ov_n), .output_oe(q_oe),
    .expansion_chain_output(xout), .active_config(cfg), .serial_port_enable(sport), .test_port_enable(tport),
    .host_io_ready(ready));
  // Inputs set here move 5 ns after a rising edge; host_reads moves its outputs 2 ns after.
  task tick(input integer k);
    begin
      repeat (k) @(posedge clock);
      #5;
    end
  endtask
  task check(input [7:0] seen, input [7:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  // One event cycle, then three edges so the busses have settled.
  task evt(input [31:0] v);
    begin
      {ae_set, ae_clr, af_set, af_clr} = v;
      tick(1);
      {ae_set, ae_clr, af_set, af_clr} = 32'h0;
      tick(3);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // A hang is cut off well past the expected run of about a hundred cycles.
  initial begin
    #200000;
    fails = fails + 1;
    finish_test;
  end
  // Main sequence of tests.
  initial begin
    tick(12);
    rst = 1'b0;
    tick(3);
    check({ae_oe, af_oe}, 2'b11);
    evt(32'h08000000);
    check(ae_bus, 8'hf7);
    check(ae_flag, 1'b0);
    evt(32'h00080000);
    check(ae_bus, 8'hff);
    evt(32'h08000000);
    // A skewed release holds the bus low one edge longer than a clean one.
    skew = 1'b1;
    ae_clr = 8'h08;
    tick(1);
    ae_clr = 8'h00;
    skew = 1'b0;
    tick(2);
    check(ae_bus, 8'hf7);
    tick(1);
    check(ae_bus, 8'hff);
    evt(32'h00000200);
    check({af_bus, af_flag}, 9'h1fa);
    evt(32'h00000002);
    check(af_bus, 8'hff);
    $display("test flag latency done");
    // Give both busses away to device five, then take them back.
    for (n = 0; n < 2; n = n + 1) begin
      dev = n ? 3'h0 : 3'h5;
      {ae_stb, af_stb} = 2'b11;
      tick(1);
      {ae_stb, af_stb} = 2'b00;
      tick(2);
      check({ae_oe, af_oe}, n ? 2'b11 : 2'b00);
    end
    $display("test handover done");
    run = 1'b1;
    tick(2);
    // Echo enable is low exactly one edge after a read of an available word.
    for (n = 0; n < 22; n = n + 1) begin
      exp_n = rd_n | ~avail;
      tick(1);
      check(echo_n, exp_n);
    end
    run = 1'b0;
    tick(5);
    check({echo_n, ov_n, xout}, 3'h6);
    $display("test echo done");
    pd = 1'b1;
    tick(1);
    check({ae_oe, af_oe, q_oe, ready}, 4'h0);
    check({f_oe, tport, sport, echo_n}, 4'h1);
    cfg_in = 8'h3c;
    tick(4);
    check(cfg, 8'h5a);
    pd = 1'b0;
    tick(5);
    check(ready, 1'b0);
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      tick(1);
      n = n + 1;
    end
    check(n > 3 && n < 8, 1'b1);
    tick(1);
    check({ae_oe, af_oe, q_oe}, 3'h7);
    check({f_oe, tport, sport, cfg}, 11'h73c);
    run = 1'b1;
    tick(10);
    $display("test power down done");
    finish_test;
  end
endmodule // queue_flag_status_test
`default_nettype wire
